// [rtl/uhf_dev.sv]
/*
 * Device end of the flow-controlled serial port: transmitter, receiver, receive FIFO.
 * Assumes CLK_SYS at 40 MHz, synchronous active-low RST_N, partner on the link interface.
 */
// Function
// [RL1] Full-duplex independent TX/RX up to 1 Mbps
// [RL2] Optional ninth parity bit generated and checked
// [RL3] RTS driven out, CTS sampled in
// [RL4] Handshake lines are active low
// [RL5] Data lines idle high
// [RL6] TX output driven high after reset
// [RL7] RX reads idle high when undriven
// [RL8] RTS low after reset: ready to receive
// [RL9] CTS undriven reads asserted
// [RL10] Partner TX to our RX, crossed
// [RL11] Partner stops sending when RTS deasserts
// [RL12] Linked handshakes only for testing
// [RL13] Code downloads arrive on same port
// [RL14] Start, data LSB first, parity, stop
`timescale 1ns/1ps
`include "uhf_cfg.svh"
module uhf_dev
  import uhf_pkg::*;
#(
  parameter int CLK_HZ = `UHF_CLK_HZ,
  parameter int BAUD = `UHF_BAUD_DEF,
  parameter int FIFO_DEPTH = `UHF_FIFO_DEPTH
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  uhf_link_if.dev LINK,
  input wire logic PAR_EN,
  input wire logic PAR_ODD,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic RX_PAR_ERR,
  output logic RX_FRM_ERR,
  output logic RX_OVERRUN
);
  localparam int DIV = CLK_HZ / BAUD;
  localparam int CW = $clog2(DIV + 1);
  localparam int FL = $clog2(FIFO_DEPTH) + 1;
  // Depth must leave room above the handshake threshold
  if (BAUD > `UHF_BAUD_MAX || DIV < 4 || FIFO_DEPTH <= `UHF_FIFO_AFULL) begin : g_bad_cfg
    $error("uhf_dev: baud rate or depth not supported"); // [RL1]
  end

  // ****************************************
  // Transmitter
  // ****************************************
  uhf_state_t tx_state;
  logic [CW-1:0] tx_cnt;
  logic [2:0] tx_bit;
  logic [7:0] tx_sh;
  logic tx_par;
  logic txd;
  logic cts_q;
  wire tx_tick = (tx_cnt == CW'(DIV - 1));
  wire cts_ok = (cts_q == `UHF_HS_ASSERT); // [RL4]
  assign TX_READY = (tx_state == UHF_IDLE) && cts_ok; // [RL3]
  // Undriven CTS (X or Z) is taken as asserted, as a pull-down would make it
  wire cts_in = (LINK.dev_cts_n === 1'b1) ? `UHF_HS_DEASSERT : `UHF_HS_ASSERT; // [RL9]
  assign LINK.dev_txd = txd;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      cts_q <= `UHF_HS_ASSERT;
      tx_state <= UHF_IDLE;
      tx_cnt <= '0;
      tx_bit <= '0;
      tx_sh <= '0;
      tx_par <= 1'b0;
      txd <= `UHF_IDLE_LVL; // [RL6]
    end else begin
      cts_q <= cts_in;
      tx_cnt <= (tx_state == UHF_IDLE || tx_tick) ? '0 : tx_cnt + 1'b1;
      case (tx_state)
        UHF_IDLE: begin
          txd <= `UHF_IDLE_LVL; // [RL5]
          if (TX_VALID && TX_READY) begin
            tx_sh <= TX_DATA;
            tx_par <= uhf_parity(TX_DATA, PAR_ODD); // [RL2]
            txd <= `UHF_START_LVL; // [RL14]
            tx_state <= UHF_START;
          end
        end
        UHF_START: if (tx_tick) begin
          txd <= tx_sh[0]; // [RL14]
          tx_sh <= tx_sh >> 1;
          tx_bit <= '0;
          tx_state <= UHF_DATA;
        end
        UHF_DATA: if (tx_tick) begin
          tx_bit <= tx_bit + 1'b1;
          if (tx_bit == 3'd7) begin
            txd <= PAR_EN ? tx_par : `UHF_STOP_LVL; // [RL2]
            tx_state <= PAR_EN ? UHF_PAR : UHF_STOP;
          end else begin
            txd <= tx_sh[0];
            tx_sh <= tx_sh >> 1;
          end
        end
        UHF_PAR: if (tx_tick) begin
          txd <= `UHF_STOP_LVL;
          tx_state <= UHF_STOP;
        end
        UHF_STOP: if (tx_tick) begin
          txd <= `UHF_IDLE_LVL;
          tx_state <= UHF_IDLE;
        end
        default: begin
          txd <= `UHF_IDLE_LVL;
          tx_state <= UHF_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Receiver
  // ****************************************
  uhf_state_t rx_state;
  logic [CW-1:0] rx_cnt;
  logic [2:0] rx_bit;
  logic [7:0] rx_sh;
  logic rx_perr;
  logic rxd_q;
  logic [9:0] push_word;
  logic push_valid;
  logic rts_n;
  logic [FL-1:0] fifo_level;
  logic fifo_in_ready;
  logic [9:0] fifo_out;
  // Undriven RX (X or Z) reads idle, as a pull-up would make it
  wire rxd_in = (LINK.dev_rxd === 1'b0) ? 1'b0 : `UHF_IDLE_LVL; // [RL7]
  wire rx_tick = (rx_cnt == CW'(DIV - 1));
  wire rx_mid = (rx_cnt == CW'(DIV / 2));

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rxd_q <= `UHF_IDLE_LVL;
      rx_state <= UHF_IDLE;
      rx_cnt <= '0;
      rx_bit <= '0;
      rx_sh <= '0;
      rx_perr <= 1'b0;
      push_word <= '0;
      push_valid <= 1'b0;
      RX_OVERRUN <= 1'b0;
    end else begin
      rxd_q <= rxd_in;
      push_valid <= 1'b0;
      RX_OVERRUN <= 1'b0;
      rx_cnt <= (rx_state == UHF_IDLE || rx_tick) ? '0 : rx_cnt + 1'b1;
      case (rx_state)
        UHF_IDLE: if (rxd_q == `UHF_START_LVL) begin
          rx_state <= UHF_START; // [RL1]
        end
        UHF_START: if (rx_mid) begin
          // A start bit gone high by mid-bit is a glitch
          rx_state <= (rxd_q == `UHF_START_LVL) ? UHF_START : UHF_IDLE;
        end else if (rx_tick) begin
          rx_bit <= '0;
          rx_state <= UHF_DATA;
        end
        UHF_DATA: begin
          if (rx_mid) rx_sh <= {rxd_q, rx_sh[7:1]}; // [RL14]
          if (rx_tick) begin
            rx_bit <= rx_bit + 1'b1;
            if (rx_bit == 3'd7) rx_state <= PAR_EN ? UHF_PAR : UHF_STOP;
          end
        end
        UHF_PAR: begin
          if (rx_mid) rx_perr <= (rxd_q != uhf_parity(rx_sh, PAR_ODD)); // [RL2]
          if (rx_tick) rx_state <= UHF_STOP;
        end
        UHF_STOP: if (rx_mid) begin
          // Hand over at mid stop bit so the next start edge is not missed
          push_word <= {rxd_q != `UHF_STOP_LVL, PAR_EN && rx_perr, rx_sh}; // [RL14]
          push_valid <= 1'b1;
          RX_OVERRUN <= !fifo_in_ready;
          rx_perr <= 1'b0;
          rx_state <= UHF_IDLE;
        end
        default: rx_state <= UHF_IDLE;
      endcase
    end
  end

  // Receive FIFO holds program downloads and data alike
  uhf_fifo #(.WIDTH(10), .DEPTH(FIFO_DEPTH)) u_rx_fifo (
    .clk(CLK_SYS),
    .rst_n(RST_N),
    .in_data(push_word),
    .in_valid(push_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(RX_VALID),
    .out_ready(RX_READY),
    .level(fifo_level)
  ); // [RL13]

  // Deassert RTS while headroom for in-flight characters remains
  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rts_n <= `UHF_HS_ASSERT; // [RL8]
    end else begin
      rts_n <= (fifo_level >= FL'(FIFO_DEPTH - `UHF_FIFO_AFULL)) ?
               `UHF_HS_DEASSERT : `UHF_HS_ASSERT; // [RL3] [RL4] [RL11]
    end
  end
  assign LINK.dev_rts_n = rts_n;
  assign RX_DATA = fifo_out[7:0];
  assign RX_PAR_ERR = fifo_out[8];
  assign RX_FRM_ERR = fifo_out[9];
endmodule

// [common/uhf_cfg.svh]
/*
 * Constants of the flow-controlled serial port: clock, line rate, framing, timing.
 * Assumes inclusion by bare name from package and modules.
 */
`ifndef UHF_CFG_SVH
`define UHF_CFG_SVH
`define UHF_CLK_HZ 40000000
`define UHF_BAUD_MAX 1000000
`define UHF_BAUD_DEF 1000000
`define UHF_DATA_BITS 8
`define UHF_FIFO_DEPTH 32
`define UHF_FIFO_AFULL 4
`define UHF_IDLE_LVL 1'b1
`define UHF_START_LVL 1'b0
`define UHF_STOP_LVL 1'b1
`define UHF_HS_ASSERT 1'b0
`define UHF_HS_DEASSERT 1'b1
`endif

// [common/uhf_pkg.sv]
/*
 * Types shared by both ends of the serial port.
 * Assumes uhf_cfg.svh is on the include path.
 */
package uhf_pkg;
  `include "uhf_cfg.svh"
  typedef enum logic [4:0] {
    UHF_IDLE = 5'b0_0001,
    UHF_START = 5'b0_0010,
    UHF_DATA = 5'b0_0100,
    UHF_PAR = 5'b0_1000,
    UHF_STOP = 5'b1_0000
  } uhf_state_t;
  function automatic logic uhf_parity(input logic [`UHF_DATA_BITS-1:0] d, input logic odd);
    uhf_parity = (^d) ^ odd;
  endfunction
endpackage

// [common/uhf_link_if.sv]
/*
 * Link between the serial port device and its partner: two data lines, two handshakes.
 * Assumes the testbench joins the two modports; no pull resistors are modelled.
 */
`timescale 1ns/1ps
interface uhf_link_if;
  logic dev_txd;
  logic dev_rxd;
  logic dev_rts_n;
  logic dev_cts_n;
  modport dev (output dev_txd, input dev_rxd, output dev_rts_n, input dev_cts_n);
  modport host (input dev_txd, output dev_rxd, input dev_rts_n, output dev_cts_n);
endinterface

// [rtl/uhf_fifo.sv]
/*
 * Synchronous FIFO with valid/ready on both sides.
 * Assumes one clock and synchronous active-low reset.
 */
`timescale 1ns/1ps
module uhf_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_cfg
    $error("uhf_fifo: DEPTH must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  assign level = wr_ptr - rd_ptr;
  assign in_ready = (level != DEPTH[AW:0]);
  assign out_valid = (level != '0);
  assign out_data = mem[rd_ptr[AW-1:0]];
  always_ff @(posedge clk) begin
    if (push) mem[wr_ptr[AW-1:0]] <= in_data;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (push) wr_ptr <= wr_ptr + 1'b1;
      if (pop) rd_ptr <= rd_ptr + 1'b1;
    end
  end
endmodule

// [rtl/uhf_host.sv]
/*
 * Partner end of the serial port: starts a character only while device RTS is asserted,
 * receives the device's TX line, and drives CTS toward the device.
 * Assumes same clock and framing settings as the device end.
 */
`timescale 1ns/1ps
`include "uhf_cfg.svh"
module uhf_host
  import uhf_pkg::*;
#(
  parameter int CLK_HZ = `UHF_CLK_HZ,
  parameter int BAUD = `UHF_BAUD_DEF
) (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  uhf_link_if.host LINK,
  input wire logic PAR_EN,
  input wire logic PAR_ODD,
  input wire logic HOLD_DEV,
  input wire logic [7:0] TX_DATA,
  input wire logic TX_VALID,
  output logic TX_READY,
  output logic [7:0] RX_DATA,
  output logic RX_VALID,
  output logic RX_ERR
);
  localparam int DIV = CLK_HZ / BAUD;
  localparam int CW = $clog2(DIV + 1);
  if (BAUD > `UHF_BAUD_MAX || DIV < 4) begin : g_bad_cfg
    $error("uhf_host: baud rate not supported");
  end
  logic [CW-1:0] tcnt;
  logic [CW-1:0] rcnt;
  logic [3:0] tbit;
  logic [3:0] rbit;
  logic [10:0] tsh;
  logic [9:0] rsh;
  logic tbusy;
  logic rbusy;
  logic rts_q;
  logic rxd_q;
  logic cts_n;
  wire [3:0] nbits = PAR_EN ? 4'd11 : 4'd10;
  wire ttick = (tcnt == CW'(DIV - 1));
  wire rmid = (rcnt == CW'(DIV / 2));
  // Start only while the device asks for data [RL11] [RL4]
  assign TX_READY = !tbusy && (rts_q == `UHF_HS_ASSERT);
  assign LINK.dev_rxd = tsh[0]; // [RL10] [RL5]
  assign LINK.dev_cts_n = cts_n;

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rts_q <= `UHF_HS_DEASSERT;
      cts_n <= `UHF_HS_DEASSERT;
      tbusy <= 1'b0;
      tcnt <= '0;
      tbit <= '0;
      tsh <= {11{`UHF_IDLE_LVL}};
    end else begin
      rts_q <= LINK.dev_rts_n; // [RL3]
      // CTS has its own hold control and is never looped back from RTS
      cts_n <= HOLD_DEV ? `UHF_HS_DEASSERT : `UHF_HS_ASSERT; // [RL3] [RL12]
      tcnt <= (!tbusy || ttick) ? '0 : tcnt + 1'b1;
      if (!tbusy && TX_VALID && TX_READY) begin
        tsh <= PAR_EN ? {`UHF_STOP_LVL, uhf_parity(TX_DATA, PAR_ODD), TX_DATA, `UHF_START_LVL}
                      : {2'b11, TX_DATA, `UHF_START_LVL};
        tbit <= '0;
        tbusy <= 1'b1;
      end else if (tbusy && ttick) begin
        tsh <= {`UHF_IDLE_LVL, tsh[10:1]};
        tbit <= tbit + 1'b1;
        if (tbit == nbits - 4'd1) tbusy <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RST_N) begin
      rxd_q <= `UHF_IDLE_LVL;
      rbusy <= 1'b0;
      rcnt <= '0;
      rbit <= '0;
      rsh <= '0;
      RX_DATA <= '0;
      RX_VALID <= 1'b0;
      RX_ERR <= 1'b0;
    end else begin
      rxd_q <= LINK.dev_txd; // [RL10]
      RX_VALID <= 1'b0;
      rcnt <= (!rbusy || rcnt == CW'(DIV - 1)) ? '0 : rcnt + 1'b1;
      if (!rbusy) begin
        rbusy <= (rxd_q == `UHF_START_LVL);
        rbit <= '0;
      end else if (rmid) begin
        rsh <= {rxd_q, rsh[9:1]};
        rbit <= rbit + 1'b1;
        if (rbit == nbits - 4'd1) begin
          rbusy <= 1'b0;
          RX_VALID <= 1'b1;
          RX_DATA <= PAR_EN ? rsh[8:1] : rsh[9:2];
          RX_ERR <= (rxd_q != `UHF_STOP_LVL) ||
                    (PAR_EN && rsh[9] != uhf_parity(rsh[8:1], PAR_ODD));
        end
      end
    end
  end
endmodule

// [verif/uhf_monitor.sv]
/* Wire checker for the serial link: idle levels, bit lengths, handshakes.
   Assumes instantiation beside the link interface, one clock, sync reset. */
`timescale 1ns/1ps
module uhf_monitor (
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic dev_txd,
  input wire logic dev_rxd,
  input wire logic dev_rts_n,
  input wire logic dev_cts_n
);
  logic [8:0] tlo, thi, rlo, rhi;
  // ****************
  // Run-length counters
  // ****************
  always_ff @(posedge CLK_SYS) begin
    tlo <= (!RST_N || dev_txd) ? 9'h000 : tlo + 9'h001;
    rlo <= (!RST_N || dev_rxd) ? 9'h000 : rlo + 9'h001;
    thi <= !RST_N ? 9'h1ff : dev_txd ? thi + {8'h00, thi != 9'h1ff} : 9'h000;
    rhi <= !RST_N ? 9'h1ff : dev_rxd ? rhi + {8'h00, rhi != 9'h1ff} : 9'h000;
  end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  reset_dev_a: assert property ($rose(RST_N) |-> dev_txd && !dev_rts_n)
    else $error("device lines not idle after reset");
  reset_host_a: assert property ($rose(RST_N) |-> dev_rxd && dev_cts_n)
    else $error("host lines not idle after reset");
  tx_low_a: assert property ($rose(dev_txd) |-> tlo % 40 == 0 && tlo <= 400)
    else $error("tx low run not whole bits");
  rx_low_a: assert property ($rose(dev_rxd) |-> rlo % 40 == 0 && rlo <= 400)
    else $error("rx low run not whole bits");
  tx_high_a: assert property ($fell(dev_txd) |-> thi >= 40)
    else $error("tx high run too short");
  rx_high_a: assert property ($fell(dev_rxd) |-> rhi >= 40)
    else $error("rx high run too short");
  tx_cts_a: assert property ($fell(dev_txd) |->
    !($past(dev_cts_n, 2) && $past(dev_cts_n, 3) && $past(dev_cts_n, 4)))
    else $error("tx started while cts high");
  rx_rts_a: assert property ($fell(dev_rxd) |->
    !($past(dev_rts_n, 2) && $past(dev_rts_n, 3) && $past(dev_rts_n, 4)))
    else $error("rx started while rts high");
  tx_start_c: cover property ($fell(dev_txd));
  rx_start_c: cover property ($fell(dev_rxd));
  rts_off_c: cover property ($rose(dev_rts_n));
endmodule

// [verif/uhf_tb.sv]
/* Testbench joining device and host ends of the serial port.
   Assumes a 40 MHz clock and the default divider of 40 cycles per bit. */
`timescale 1ns/1ps
module uhf_tb;
  import uhf_pkg::*;
  logic CLK_SYS = 1'b0;
  logic RST_N = 1'b0;
  logic dpe = 1'b0, dpo = 1'b0, hpe = 1'b0, hpo = 1'b0, hold = 1'b0;
  logic dtv = 1'b0, drr = 1'b0, htv = 1'b0, he;
  logic ovr = 1'b0;
  logic [7:0] dtd = 8'h00, htd = 8'h00, hg;
  wire logic dtr, drv, dpr, dfe, htr, hrv, hre, dov;
  wire logic [7:0] drd, hrd;
  int err_count = 0, compares = 0, hn = 0;
  uhf_link_if lnk ();
  uhf_dev u_uhf_dev (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .LINK(lnk.dev), .PAR_EN(dpe),
    .PAR_ODD(dpo), .TX_DATA(dtd), .TX_VALID(dtv), .TX_READY(dtr), .RX_DATA(drd),
    .RX_VALID(drv), .RX_READY(drr), .RX_PAR_ERR(dpr), .RX_FRM_ERR(dfe), .RX_OVERRUN(dov));
  uhf_host u_uhf_host (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .LINK(lnk.host), .PAR_EN(hpe),
    .PAR_ODD(hpo), .HOLD_DEV(hold), .TX_DATA(htd), .TX_VALID(htv), .TX_READY(htr),
    .RX_DATA(hrd), .RX_VALID(hrv), .RX_ERR(hre));
  uhf_monitor u_uhf_monitor (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .dev_txd(lnk.dev_txd),
    .dev_rxd(lnk.dev_rxd), .dev_rts_n(lnk.dev_rts_n), .dev_cts_n(lnk.dev_cts_n));
  initial forever #12.5 CLK_SYS = ~CLK_SYS;
  always @(posedge CLK_SYS) begin
    if (dov === 1'b1) ovr <= 1'b1;
    if (hrv === 1'b1) begin
      hg <= hrd;
      he <= hre;
      hn <= hn + 1;
    end
  end
  // ****************
  // Tasks
  // ****************
  task automatic bad(input string m);
    err_count++;
    $display("[FAIL] %0t %s", $time, m);
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
    compares++;
    if (g !== e) bad(m);
  endtask
  task automatic chk1(input logic g, input logic e, input string m);
    compares++;
    if (g !== e) bad(m);
  endtask
  task automatic summarize();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Device sends one word; the wire is sampled mid-bit
  task automatic dsend(input logic [7:0] d, input logic xe);
    logic [10:0] f;
    int n;
    n = hn;
    @(posedge CLK_SYS);
    // Built after the edge so a parity setting made just before is seen
    f = dpe ? {1'b1, ^d ^ dpo, d, 1'b0} : {2'b11, d, 1'b0};
    dtd <= d;
    dtv <= 1'b1;
    for (int i = 0; i < 2000; i++) begin
      @(negedge CLK_SYS);
      if (dtr === 1'b1) break;
    end
    chk1(dtr, 1'b1, "tx taken");
    @(posedge CLK_SYS);
    dtv <= 1'b0;
    repeat (20) @(negedge CLK_SYS);
    for (int i = 0; i < 10 + int'(dpe); i++) begin
      chk1(lnk.dev_txd, f[i], "tx wire bit");
      repeat (40) @(negedge CLK_SYS);
    end
    chk1(lnk.dev_txd, 1'b1, "tx idle");
    repeat (4) @(negedge CLK_SYS);
    chk1(hn == n + 1, 1'b1, "host word count");
    chk8(hg, d, "host data");
    chk1(he, xe, "host error flag");
  endtask
  task automatic hsend(input logic [7:0] d);
    @(posedge CLK_SYS);
    htd <= d;
    htv <= 1'b1;
    for (int i = 0; i < 2000; i++) begin
      @(negedge CLK_SYS);
      if (htr === 1'b1) break;
    end
    chk1(htr, 1'b1, "host tx taken");
    @(posedge CLK_SYS);
    htv <= 1'b0;
  endtask
  task automatic pop(input logic [7:0] d, input logic pe, input logic fe);
    for (int i = 0; i < 2000; i++) begin
      @(negedge CLK_SYS);
      if (drv === 1'b1) break;
    end
    chk1(drv, 1'b1, "rx valid");
    chk8(drd, d, "rx data");
    chk1(dpr, pe, "rx parity flag");
    chk1(dfe, fe, "rx frame flag");
    @(posedge CLK_SYS);
    drr <= 1'b1;
    @(posedge CLK_SYS);
    drr <= 1'b0;
  endtask
  // ****************
  // Tests
  // ****************
  initial begin
    repeat (3) @(negedge CLK_SYS);
    chk1(lnk.dev_txd, 1'b1, "txd in reset");
    chk1(lnk.dev_rts_n, 1'b0, "rts in reset");
    @(posedge CLK_SYS);
    RST_N <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    fork
      dsend(8'h5A, 1'b0);
      begin
        hsend(8'hC3);
        pop(8'hC3, 1'b0, 1'b0);
      end
    join
    $display("test duplex done");
    for (int k = 0; k < 2; k++) begin
      @(posedge CLK_SYS);
      {dpe, hpe, dpo, hpo} <= {2'b11, k[0], k[0]};
      dsend(8'h96 ^ 8'(k), 1'b0);
      hsend(8'h3C ^ 8'(k));
      pop(8'h3C ^ 8'(k), 1'b0, 1'b0);
    end
    @(posedge CLK_SYS);
    hpo <= 1'b0;
    dsend(8'h11, 1'b1);
    hsend(8'h22);
    pop(8'h22, 1'b1, 1'b0);
    @(posedge CLK_SYS);
    {dpe, hpo} <= 2'b00;
    hsend(8'h03);
    pop(8'h03, 1'b0, 1'b1);
    @(posedge CLK_SYS);
    hpe <= 1'b0;
    $display("test parity done");
    @(posedge CLK_SYS);
    hold <= 1'b1;
    repeat (4) @(negedge CLK_SYS);
    chk1(lnk.dev_cts_n, 1'b1, "cts held");
    chk1(dtr, 1'b0, "tx refused");
    fork
      dsend(8'h77, 1'b0);
      begin
        repeat (200) @(negedge CLK_SYS);
        chk1(lnk.dev_txd, 1'b1, "no tx while held");
        @(posedge CLK_SYS);
        hold <= 1'b0;
      end
    join
    $display("test cts done");
    fork
      for (int k = 0; k < 29; k++) hsend(8'(k));
      begin
        repeat (12500) @(negedge CLK_SYS);
        chk1(lnk.dev_rts_n, 1'b1, "rts off when full");
        chk1(htr, 1'b0, "host stopped");
        for (int k = 0; k < 29; k++) pop(8'(k), 1'b0, 1'b0);
      end
    join
    @(negedge CLK_SYS);
    chk1(lnk.dev_rts_n, 1'b0, "rts on when empty");
    chk1(drv, 1'b0, "fifo empty");
    chk1(ovr, 1'b0, "no overrun");
    $display("test fill done");
    summarize();
  end
  initial begin
    repeat (60000) @(posedge CLK_SYS);
    bad("timeout");
    summarize();
  end
endmodule
